// *** common/slice_pkg.sv ***
/*
 * constants and carrier types for the arbiter time-slice block.
 * assumes a 40 MHz core clock and a plain strobe register port.
 */
// Function
// - current agent keeps the bus for the multi-transaction slice, then another is granted if one is waiting.
// - multi-transaction register at zero (reset value) disables that slice entirely.
// - multi-transaction slice steps by eight clocks; register value equals clocks.
// - processor transactions are governed by the same multi-transaction slice.
// - low-priority timer sets minimum tenure for low-priority reads and writes, either queue.
// - low-priority slice spans the whole transfer state, across same-type transactions.
// - after low-priority expiry, hand over only if another request is pending.
// - high-priority requests are never delayed; ownership passes to them at once.
// - low-priority register at zero (reset value) disables that minimum tenure.
// - low-priority count in bits 7:3, eight-clock granularity; bits 2:0 reserved.
// - both slices act only in graphics-port mode, not display-cache mode.
package slice_pkg;
  localparam logic [7:0] MTS_OFFSET = 8'hbc;
  localparam logic [7:0] LPS_OFFSET = 8'hbd;
  localparam logic [7:0] STATUS_OFFSET = 8'hbf;
  localparam logic [7:0] SLICE_RESET = 8'h00;
  localparam logic [7:0] COUNT_MASK = 8'hf8;
  localparam int COUNT_LSB = 3;
  localparam int AGENT_W = 2;

  typedef enum logic [1:0] {
    AG_NONE = 2'b00,
    AG_MASTER = 2'b01,
    AG_HOST = 2'b10,
    AG_HIPRI = 2'b11
  } agent_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } regreq_s;
endpackage

// *** rtl/slice_timer.sv ***
/*
 * one down-counting slice timer.
 * assumes load and tick come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module slice_timer #(
  parameter int W = 8
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // sync reset, low
  input wire logic load, // start of a new tenure
  input wire logic [W-1:0] loadVal, // slice length in clocks
  input wire logic tick, // one link clock elapsed
  output logic expired // slice used up
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  assign cnt_nxt = load ? loadVal : ((tick && cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign expired = (cnt_r == '0);
  always_ff @(posedge clk) begin
    if (!rst_n) cnt_r <= '0;
    else cnt_r <= cnt_nxt;
  end
endmodule // slice_timer
`default_nettype wire

// *** rtl/slice_arbiter.sv ***
/*
 * time-slice arbiter for the graphics port: bus master, host bridge and
 * a high-priority queue compete; two programmable slices set tenures.
 * assumes requests are synchronous to clk and linkTick pulses once per
 * 66 MHz link clock as seen in this domain.
 */
`timescale 1ns/10ps
`default_nettype none
module slice_arbiter (
  input wire logic clk, // core clock
  input wire logic rst_n, // sync reset, low
  input wire slice_pkg::regreq_s regReq, // register access
  output logic [7:0] regRdata, // read data, cycle after read
  input wire logic linkTick, // one pulse per link clock
  input wire logic agpMode, // high in graphics-port mode
  input wire logic reqMaster, // bus master request
  input wire logic reqHost, // host bridge request
  input wire logic reqHiPri, // high-priority queue request
  input wire logic lowPriXfer, // low-priority data state active
  input wire logic lowPriRead, // low-priority transfer is a read
  output slice_pkg::agent_e grant // current owner
);
  import slice_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] mtSlice_r;
  logic [7:0] lpSlice_r;
  logic [7:0] rdata_r;
  wire hitMt = regReq.addr == MTS_OFFSET;
  wire hitLp = regReq.addr == LPS_OFFSET;
  wire hitSt = regReq.addr == STATUS_OFFSET;
  wire [7:0] wrMasked = regReq.wdata & COUNT_MASK;
  agent_e grant_r;
  agent_e grant_nxt;
  logic mtExp;
  logic lpExp;
  logic lpActive_r;
  logic lpRead_r;
  wire [7:0] status = {lpActive_r, lpRead_r, mtExp, lpExp, 2'b00, grant_r};
  wire [7:0] rdSel = hitMt ? mtSlice_r : hitLp ? lpSlice_r : hitSt ? status : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mtSlice_r <= SLICE_RESET;
      lpSlice_r <= SLICE_RESET;
      rdata_r <= 8'h00;
    end else begin
      if (regReq.wr && hitMt) mtSlice_r <= wrMasked;
      if (regReq.wr && hitLp) lpSlice_r <= wrMasked;
      rdata_r <= regReq.rd ? rdSel : 8'h00;
    end
  end
  assign regRdata = rdata_r;

  // ****************************************
  // slice timers
  // ****************************************
  // a slice is live only in graphics-port mode with a nonzero setting
  wire mtOn = agpMode && (mtSlice_r != 8'h00);
  wire lpOn = agpMode && (lpSlice_r != 8'h00);
  wire newGrant = grant_nxt != grant_r;
  // low-priority state restarts on entry or on a change of read/write type
  wire lpEnter = lowPriXfer && (!lpActive_r || lpRead_r != lowPriRead);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lpActive_r <= 1'b0;
      lpRead_r <= 1'b0;
    end else begin
      lpActive_r <= lowPriXfer;
      lpRead_r <= lowPriRead;
    end
  end

  slice_timer #(.W(8)) mtTimer (
    .clk(clk),
    .rst_n(rst_n),
    .load(newGrant),
    .loadVal(mtSlice_r),
    .tick(linkTick),
    .expired(mtExp)
  );

  slice_timer #(.W(8)) lpTimer (
    .clk(clk),
    .rst_n(rst_n),
    .load(lpEnter),
    .loadVal(lpSlice_r),
    .tick(linkTick),
    .expired(lpExp)
  );

  // ****************************************
  // arbitration
  // ****************************************
  wire mtHold = mtOn && !mtExp;
  wire lpHold = lpOn && lowPriXfer && lpActive_r && !lpExp;
  wire curReq = (grant_r == AG_MASTER) ? reqMaster :
                (grant_r == AG_HOST) ? reqHost :
                (grant_r == AG_HIPRI) ? reqHiPri : 1'b0;
  wire otherReq = (grant_r != AG_MASTER && reqMaster) || (grant_r != AG_HOST && reqHost);
  // a master or host owner that still requests keeps the bus while a slice holds; after expiry only a waiting
  // request takes it, otherwise the current owner carries on
  wire keep = curReq && (mtHold || lpHold || !otherReq);
  // round robin between master and host avoids starving either side
  agent_e rrPick;
  // a master that has dropped its request must not be handed the bus again
  assign rrPick = (grant_r == AG_MASTER) ? (reqHost ? AG_HOST : (reqMaster ? AG_MASTER : AG_NONE)) :
                  (reqMaster ? AG_MASTER : (reqHost ? AG_HOST : AG_NONE));

  always_comb begin
    grant_nxt = grant_r;
    if (reqHiPri) grant_nxt = AG_HIPRI;
    else if (keep && grant_r != AG_HIPRI) grant_nxt = grant_r;
    else grant_nxt = rrPick;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) grant_r <= AG_NONE;
    else grant_r <= grant_nxt;
  end
  assign grant = grant_r;
endmodule // slice_arbiter
`default_nettype wire

// *** verif/slice_arbiter_props.sv ***
/* slice_arbiter port checker; bound to every instance */
`timescale 1ns/10ps
`default_nettype none
module slice_arbiter_props (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire slice_pkg::regreq_s regReq, // reg access
  input wire logic [7:0] regRdata, // read data
  input wire logic agpMode, // mode
  input wire logic reqMaster, // master
  input wire logic reqHost, // host
  input wire logic reqHiPri, // hi queue
  input wire slice_pkg::agent_e grant // owner
);
  import slice_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_HIPRI: assert property (reqHiPri |=> grant == AG_HIPRI) else $error("hipri late");
  AST_HP: assert property (grant == AG_HIPRI |-> $past(reqHiPri)) else $error("hp");
  AST_M: assert property (grant == AG_MASTER |-> $past(reqMaster)) else $error("m");
  AST_H: assert property (grant == AG_HOST |-> $past(reqHost)) else $error("h");
  AST_MRSV: assert property (regReq.rd && regReq.addr == MTS_OFFSET |=>
    regRdata[2:0] == 3'h0) else $error("mts low");
  AST_LRSV: assert property (regReq.rd && regReq.addr == LPS_OFFSET |=>
    regRdata[2:0] == 3'h0) else $error("lps low");
  AST_WRRD: assert property (regReq.rd && $past(regReq.wr) && $past(regReq.addr) == MTS_OFFSET
    && regReq.addr == MTS_OFFSET |=> regRdata == ($past(regReq.wdata, 2) & COUNT_MASK))
    else $error("mts rw");
  AST_MODE: assert property (!agpMode && reqMaster && reqHost && !reqHiPri
    && grant == AG_MASTER |=> grant == AG_HOST) else $error("mode");
endmodule // slice_arbiter_props
bind slice_arbiter slice_arbiter_props chk (.clk(clk), .rst_n(rst_n), .regReq(regReq),
  .regRdata(regRdata), .agpMode(agpMode), .reqMaster(reqMaster), .reqHost(reqHost),
  .reqHiPri(reqHiPri), .grant(grant));
`default_nettype wire

// *** verif/bus_requesters.sv ***
/* master and host requesters; bench sets what they want */
`timescale 1ns/10ps
`default_nettype none
module bus_requesters (
  input wire logic clk, // clock
  input wire logic wantM, // master wants bus
  input wire logic wantH, // host wants bus
  output logic reqMaster, // master request
  output logic reqHost // host request
);
  // requests launch just after an edge, like real agents
  always_ff @(posedge clk) begin
    reqMaster <= wantM;
    reqHost <= wantH;
  end
endmodule // bus_requesters
`default_nettype wire

// *** verif/agp_arbiter_time_slice_tb_top.sv ***
/* bench for slice_arbiter; bus_requesters drives master and host */
`timescale 1ns/10ps
`default_nettype none
module agp_arbiter_time_slice_tb_top;
  import slice_pkg::*;
  logic clk = 0, rst_n = 0, agpMode = 1, hiPri = 0, wantM = 0, wantH = 0, lowPri = 0;
  logic reqMaster, reqHost;
  logic [7:0] rdata, v;
  regreq_s regReq = '0;
  agent_e grant;
  int err_count = 0, n_compared = 0, n;
  always #12.5 clk = ~clk;
  bus_requesters req (.clk(clk), .wantM(wantM), .wantH(wantH), .reqMaster(reqMaster),
    .reqHost(reqHost));
  slice_arbiter dut (.clk(clk), .rst_n(rst_n), .regReq(regReq), .regRdata(rdata),
    .linkTick(1'b1), .agpMode(agpMode), .reqMaster(reqMaster), .reqHost(reqHost),
    .reqHiPri(hiPri), .lowPriXfer(lowPri), .lowPriRead(1'b0), .grant(grant));
  task chk(string s, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // a write stays up until the next access, so always end with a read
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) regReq <= '{a, d, 1'b1, 1'b0};
  endtask
  task rd(logic [7:0] a);
    @(posedge clk) regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) regReq <= '0;
    #1 v = rdata;
  endtask
  task summarize;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task waitChange;
    v = grant;
    n = 0;
    while (grant === v) begin
      @(posedge clk) #1 n++;
      if (n > 60) begin
        err_count++;
        summarize;
      end
    end
  endtask
  task swapCheck(string s);
    @(posedge clk) #1 v = grant;
    @(posedge clk) #1 chk(s, {6'h00, ~v[1:0]}, {6'h00, grant});
  endtask
  task t_regs;
    rd(MTS_OFFSET);
    chk("mts", 8'h00, v);
    rd(LPS_OFFSET);
    chk("lps", 8'h00, v);
    wr(LPS_OFFSET, 8'hff);
    rd(LPS_OFFSET);
    chk("lps", 8'hf8, v);
    wr(8'hc0, 8'h55);
    rd(8'hc0);
    chk("hole", 8'h00, v);
  endtask
  task t_slice;
    wr(MTS_OFFSET, 8'h1f);
    rd(MTS_OFFSET);
    chk("mts", 8'h18, v);
    wantM <= 1'b1;
    wantH <= 1'b1;
    repeat (3) @(posedge clk);
    waitChange;
    waitChange;
    chk("tenure", 8'h01, 8'(n >= 24 && n <= 26));
    @(posedge clk) hiPri <= 1'b1;
    @(posedge clk) #1 chk("hipri", 8'h03, {6'h00, grant});
    @(posedge clk) hiPri <= 1'b0;
    wr(MTS_OFFSET, 8'h00);
    rd(MTS_OFFSET);
    swapCheck("zero");
    wr(MTS_OFFSET, 8'h18);
    rd(MTS_OFFSET);
    @(posedge clk) agpMode <= 1'b0;
    swapCheck("mode");
  endtask
  // master alone owns the bus, then a low-priority state starts as the host asks
  task t_lowpri;
    @(posedge clk) begin
      agpMode <= 1'b1;
      wantH <= 1'b0;
    end
    wr(MTS_OFFSET, 8'h00);
    wr(LPS_OFFSET, 8'h10);
    rd(LPS_OFFSET);
    chk("lps", 8'h10, v);
    repeat (4) @(posedge clk);
    #1 chk("owner", 8'h01, {6'h00, grant});
    @(posedge clk) begin
      lowPri <= 1'b1;
      wantH <= 1'b1;
    end
    waitChange;
    chk("lptenure", 8'h01, 8'(n >= 16 && n <= 19));
    chk("lpnext", 8'h02, {6'h00, grant});
    @(posedge clk) begin
      lowPri <= 1'b0;
      wantM <= 1'b0;
      wantH <= 1'b0;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_slice;
    t_lowpri;
    summarize;
  end
endmodule // agp_arbiter_time_slice_tb_top
`default_nettype wire
